// ---- core/pin_sync.sv ----
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // first stage is read by the second stage only
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : pin_sync
`default_nettype wire

// ---- core/post_buck_pkg.sv ----
`default_nettype none
package post_buck_pkg;
    // clock and derived counts
    localparam int CLK_MHZ = 250;
    localparam int OCP_TIMEOUT_US = 100;
    localparam int OCP_TIMEOUT_CYC = OCP_TIMEOUT_US * CLK_MHZ;
    localparam int SW_FREQ_KHZ = 2200;
    localparam int SW_PERIOD_CYC = (CLK_MHZ * 1000) / SW_FREQ_KHZ;
    localparam int SS_STEP_US = 10;
    localparam int SS_STEP_CYC = SS_STEP_US * CLK_MHZ;

    // voltage code: 0.9 V .. 1.3 V in 50 mV steps
    localparam int VCODE_W = 4;
    localparam logic [3:0] VCODE_MAX = 4'h8;
    localparam logic [3:0] VCODE_RESET = 4'h7;
    localparam int VOUT_MIN_MV = 900;
    localparam int VOUT_STEP_MV = 50;
    localparam int VOUT_MV_W = 11;

    // apb byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h08;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h0c;
    localparam logic [7:0] OFS_VCODE = 8'h10;
    localparam logic [7:0] OFS_VCODE_CHECK = 8'h14;
    localparam logic [7:0] OFS_CTRL = 8'h18;

    // event bits of irq status / clear / enable
    localparam int NEV = 3;
    localparam int EV_OC = 0;
    localparam int EV_OTW = 1;
    localparam int EV_TSD = 2;
    localparam logic [2:0] IRQ_EN_RESET = 3'h0;

    // status bits: live warning, latched presence and detection, state
    localparam int STB_OTW_LIVE = 0;
    localparam int STB_PRESENT = 1;
    localparam int STB_RUNNING = 2;
    localparam int STB_TSD_ACTIVE = 3;
    localparam int STB_DETECTED = 4;

    // control bits
    localparam int CTRL_EN = 0;
    localparam logic CTRL_EN_RESET = 1'b1;

    // synchronised pin vector layout
    localparam int NPIN = 7;
    localparam int PIN_PEAK = 0;
    localparam int PIN_LS_OC = 1;
    localparam int PIN_OTW = 2;
    localparam int PIN_OTSD = 3;
    localparam int PIN_PRESENT = 4;
    localparam int PIN_ACTIVE = 5;
    localparam int PIN_SEQ = 6;

    typedef enum logic [2:0] {
        RS_IDLE, RS_DETECT, RS_SOFT, RS_RUN, RS_ABSENT, RS_TSD
    } rail_state_t;
endpackage : post_buck_pkg
`default_nettype wire

// ---- core/post_buck_supervisor.sv ----
`default_nettype none
module post_buck_supervisor
    import post_buck_pkg::*;
#(
    parameter int OCP_CYC = OCP_TIMEOUT_CYC,
    parameter int PERIOD_CYC = SW_PERIOD_CYC,
    parameter int SS_CYC = SS_STEP_CYC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic peak_trip,
    input wire logic ls_overcurrent,
    input wire logic overtemp_warn,
    input wire logic overtemp_shutdown,
    input wire logic post_rail_input_pins,
    input wire logic device_active,
    input wire logic seq_start,
    output logic hs_gate,
    output logic ls_gate,
    output logic rail_enable,
    output logic [VCODE_W-1:0] post_rail_voltage_code,
    output logic [VOUT_MV_W-1:0] vout_target_mv,
    output logic thermal_shutdown_event,
    output logic irq
);
    localparam int OCW = $clog2(OCP_CYC + 1);
    localparam int PW = $clog2(PERIOD_CYC + 1);
    localparam int SW = $clog2(SS_CYC + 1);

    typedef struct packed {
        rail_state_t st;
        logic [PW-1:0] per_cnt;
        logic skip_next;
        logic hs_on;
        logic ls_on;
        logic [OCW-1:0] oc_cnt;
        logic oc_done;
        logic [SW-1:0] ss_cnt;
        logic [VCODE_W-1:0] ss_code;
        logic [VCODE_W-1:0] vcode;
        logic [VCODE_W-1:0] vpend;
        logic [NEV-1:0] ev;
        logic [NEV-1:0] irq_en;
        logic en;
        logic present;
        logic detected;
        logic otw_prev;
        logic sd_prev;
        logic tsd_pulse;
        logic irq;
        logic rail_en;
        logic [VCODE_W-1:0] out_code;
        logic [VOUT_MV_W-1:0] vout_mv;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sup_state_t;

    sup_state_t s_q;
    sup_state_t s_d;
    logic [NPIN-1:0] pin_s;

    pin_sync #(
        .WIDTH(NPIN)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .async_in({seq_start, device_active, post_rail_input_pins,
                   overtemp_shutdown, overtemp_warn, ls_overcurrent,
                   peak_trip}),
        .sync_out(pin_s)
    );

    logic peak_s;
    logic ls_oc_s;
    logic otw_s;
    logic sd_s;
    logic present_s;
    logic active_s;
    logic seq_s;
    assign peak_s = pin_s[PIN_PEAK];
    assign ls_oc_s = pin_s[PIN_LS_OC];
    assign otw_s = pin_s[PIN_OTW];
    assign sd_s = pin_s[PIN_OTSD];
    assign present_s = pin_s[PIN_PRESENT];
    assign active_s = pin_s[PIN_ACTIVE];
    assign seq_s = pin_s[PIN_SEQ];

    logic running;
    logic period_end;
    logic acc;
    logic wr;
    logic [NEV-1:0] ev_set;
    logic [NEV-1:0] ev_clr;
    logic [VCODE_W-1:0] wcode;
    logic [VCODE_W-1:0] tgt_code;
    logic mapped;
    logic [31:0] rdata;

    always_comb begin
        s_d = s_q;
        running = (s_q.st == RS_SOFT) || (s_q.st == RS_RUN);
        period_end = (s_q.per_cnt == PW'(PERIOD_CYC - 1));
        acc = psel && penable;
        wr = acc && pwrite && s_q.pready;
        wcode = pwdata[VCODE_W-1:0];
        ev_set = '0;
        ev_clr = '0;
        mapped = 1'b1;
        rdata = '0;

        // switching period and gate control
        s_d.per_cnt = period_end ? '0 : s_q.per_cnt + PW'(1);
        if (!running) begin
            s_d.hs_on = 1'b0;
            s_d.skip_next = 1'b0;
        end else if (period_end) begin
            s_d.skip_next = ls_oc_s;
            s_d.hs_on = !ls_oc_s;
        end else if (peak_s) begin
            s_d.hs_on = 1'b0;
        end
        // low side conducts whenever the high side is off in a live period
        s_d.ls_on = running && !s_d.hs_on;

        // overcurrent timeout; counter stops once the flag fired
        if (!(ls_oc_s || peak_s) || !running) begin
            s_d.oc_cnt = '0;
            s_d.oc_done = 1'b0;
        end else if (!s_q.oc_done) begin
            if (s_q.oc_cnt == OCW'(OCP_CYC - 1)) begin
                ev_set[EV_OC] = 1'b1;
                s_d.oc_done = 1'b1;
            end else begin
                s_d.oc_cnt = s_q.oc_cnt + OCW'(1);
            end
        end
        // no automatic shutdown on overcurrent: the host decides

        // thermal events on rising comparator edges
        s_d.otw_prev = otw_s;
        s_d.sd_prev = sd_s;
        if (otw_s && !s_q.otw_prev) begin
            ev_set[EV_OTW] = 1'b1;
        end
        s_d.tsd_pulse = sd_s && !s_q.sd_prev;
        if (sd_s && !s_q.sd_prev) begin
            ev_set[EV_TSD] = 1'b1;
        end

        // rail sequencing
        s_d.ss_cnt = '0;
        case (s_q.st)
            RS_IDLE: begin
                if (seq_s && s_q.en && active_s && !sd_s) begin
                    s_d.st = RS_DETECT;
                end
            end
            RS_DETECT: begin
                s_d.present = present_s;
                s_d.detected = 1'b1;
                s_d.ss_code = '0;
                s_d.st = present_s ? RS_SOFT : RS_ABSENT;
            end
            RS_SOFT: begin
                s_d.ss_cnt = s_q.ss_cnt + SW'(1);
                if (s_q.ss_cnt == SW'(SS_CYC - 1)) begin
                    s_d.ss_cnt = '0;
                    if (s_q.ss_code >= s_q.vcode) begin
                        s_d.st = RS_RUN;
                    end else begin
                        s_d.ss_code = s_q.ss_code + 4'h1;
                    end
                end
            end
            RS_RUN: begin
                s_d.ss_code = s_q.vcode;
            end
            RS_ABSENT: begin
                // startup skipped; leave when the host disables or on thermal shutdown
                if (!s_q.en) begin
                    s_d.st = RS_IDLE;
                end
            end
            RS_TSD: begin
                if (!sd_s) begin
                    s_d.st = RS_IDLE;
                end
            end
            default: begin
                s_d.st = RS_IDLE;
            end
        endcase
        if (sd_s && s_q.st != RS_TSD) begin
            s_d.st = RS_TSD;
        end else if (!s_q.en && running) begin
            s_d.st = RS_IDLE;
        end

        // apb register access: one wait state on every transfer
        case (paddr)
            OFS_STATUS: begin
                rdata[STB_OTW_LIVE] = otw_s;
                rdata[STB_PRESENT] = s_q.present;
                rdata[STB_RUNNING] = running;
                rdata[STB_TSD_ACTIVE] = (s_q.st == RS_TSD);
                rdata[STB_DETECTED] = s_q.detected;
            end
            OFS_IRQ_STATUS: rdata[NEV-1:0] = s_q.ev;
            OFS_IRQ_CLEAR: rdata = '0;
            OFS_IRQ_ENABLE: rdata[NEV-1:0] = s_q.irq_en;
            OFS_VCODE: rdata[VCODE_W-1:0] = s_q.vcode;
            OFS_VCODE_CHECK: rdata[VCODE_W-1:0] = ~s_q.vcode;
            OFS_CTRL: rdata[CTRL_EN] = s_q.en;
            default: mapped = 1'b0;
        endcase
        s_d.pready = acc && !s_q.pready;
        if (acc && !s_q.pready) begin
            s_d.prdata = pwrite ? 32'h0 : rdata;
            s_d.pslverr = !mapped;
        end
        if (wr && mapped) begin
            case (paddr)
                OFS_IRQ_CLEAR: ev_clr = pwdata[NEV-1:0];
                OFS_IRQ_ENABLE: s_d.irq_en = pwdata[NEV-1:0];
                OFS_CTRL: s_d.en = pwdata[CTRL_EN];
                OFS_VCODE: begin
                    if (active_s) begin
                        s_d.vpend = wcode;
                    end
                end
                OFS_VCODE_CHECK: begin
                    // inconsistent pairs or codes beyond 1.3 V are dropped
                    if (active_s && (~wcode == s_q.vpend)
                        && s_q.vpend <= VCODE_MAX) begin
                        s_d.vcode = s_q.vpend;
                    end
                end
                default: ;
            endcase
        end

        // sticky flags, set wins over a simultaneous clear
        s_d.ev = (s_q.ev & ~ev_clr) | ev_set;
        s_d.irq = |(s_d.ev & s_q.irq_en);

        // outputs: target code follows the ramp until running
        tgt_code = (s_d.st == RS_RUN) ? s_d.vcode : s_d.ss_code;
        s_d.rail_en = (s_d.st == RS_SOFT) || (s_d.st == RS_RUN);
        s_d.out_code = tgt_code;
        s_d.vout_mv = VOUT_MV_W'(VOUT_MIN_MV
                      + int'(tgt_code) * VOUT_STEP_MV);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.st <= RS_IDLE;
            s_q.vcode <= VCODE_RESET;
            s_q.vpend <= VCODE_RESET;
            s_q.irq_en <= IRQ_EN_RESET;
            s_q.en <= CTRL_EN_RESET;
            s_q.vout_mv <= VOUT_MV_W'(VOUT_MIN_MV);
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign hs_gate = s_q.hs_on;
    assign ls_gate = s_q.ls_on;
    assign rail_enable = s_q.rail_en;
    assign post_rail_voltage_code = s_q.out_code;
    assign vout_target_mv = s_q.vout_mv;
    assign thermal_shutdown_event = s_q.tsd_pulse;
    assign irq = s_q.irq;
endmodule : post_buck_supervisor
`default_nettype wire

// ---- testbench/apb_host.sv ----
`default_nettype none
module apb_host
    import post_buck_pkg::*;
(
    input wire logic clk_sys,
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [ADDR_W-1:0] paddr = '0,
    output logic [31:0] pwdata = '0,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines must not look like a held request
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : apb_host
`default_nettype wire

// ---- testbench/post_buck_props.sv ----
`default_nettype none
module post_buck_props
    import post_buck_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic peak_trip,
    input wire logic overtemp_shutdown,
    input wire logic post_rail_input_pins,
    input wire logic hs_gate,
    input wire logic rail_enable,
    input wire logic [VCODE_W-1:0] post_rail_voltage_code,
    input wire logic [VOUT_MV_W-1:0] vout_target_mv,
    input wire logic thermal_shutdown_event,
    input wire logic irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // one cycle of high side may still start a period before the trip lands
    peak_off_a: assert property (
        peak_trip [*5] |-> !hs_gate || $rose(hs_gate))
        else $error("high side on during peak trip");
    rail_tsd_a: assert property (
        overtemp_shutdown [*6] |-> !rail_enable && !hs_gate)
        else $error("rail running in shutdown");
    tsd_pulse_a: assert property (
        thermal_shutdown_event |=> !thermal_shutdown_event)
        else $error("shutdown event longer than one cycle");
    tsd_cause_a: assert property (
        thermal_shutdown_event |-> $past(overtemp_shutdown, 2))
        else $error("shutdown event without comparator");
    vout_map_a: assert property (
        vout_target_mv == VOUT_MV_W'(VOUT_MIN_MV
        + VOUT_STEP_MV * post_rail_voltage_code))
        else $error("target voltage does not match code");
    code_max_a: assert property (
        post_rail_voltage_code <= VCODE_MAX)
        else $error("voltage code above range");
    start_pres_a: assert property (
        $rose(rail_enable) |-> $past(post_rail_input_pins, 2))
        else $error("rail started while input absent");
    ramp_step_a: assert property (
        rail_enable && $past(rail_enable)
        && $changed(post_rail_voltage_code)
        |-> post_rail_voltage_code == $past(post_rail_voltage_code) + 4'h1
        || post_rail_voltage_code == $past(post_rail_voltage_code) - 4'h1)
        else $error("code jumped while rail enabled");
    irq_mask_a: assert property (
        psel && penable && pready && pwrite && paddr == OFS_IRQ_ENABLE
        && pwdata[NEV-1:0] == 3'h0 |-> ##2 !irq [*3])
        else $error("interrupt high with all sources masked");
endmodule : post_buck_props
bind post_buck_supervisor post_buck_props i_props (.clk_sys(clk_sys),
    .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .peak_trip(peak_trip),
    .overtemp_shutdown(overtemp_shutdown), .hs_gate(hs_gate),
    .post_rail_input_pins(post_rail_input_pins), .rail_enable(rail_enable),
    .post_rail_voltage_code(post_rail_voltage_code), .irq(irq),
    .vout_target_mv(vout_target_mv),
    .thermal_shutdown_event(thermal_shutdown_event));
`default_nettype wire

// ---- testbench/post_buck_supervisor_tb.sv ----
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
    $display("wrong value at %0t: got %h exp %h", $time, (a), (b)); end end
module post_buck_supervisor_tb
    import post_buck_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, arst_n = 1'b0, psel, penable, pwrite, pready, e;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pslverr, hs_gate, ls_gate, rail_enable, tsd_ev, irq, hs_seen = 0;
    logic peak = 0, ls_oc = 0, ot_warn = 0, ot_sd = 0, pres = 1, act = 1;
    logic seq = 0;
    logic [VCODE_W-1:0] code;
    logic [VOUT_MV_W-1:0] vout;
    int err_count = 0, n_compared = 0, cyc = 0;
    always #2 clk_sys = ~clk_sys;
    post_buck_supervisor #(.OCP_CYC(50), .PERIOD_CYC(10), .SS_CYC(4))
        i_post_buck_supervisor (.clk_sys(clk_sys), .arst_n(arst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .peak_trip(peak), .ls_overcurrent(ls_oc),
        .overtemp_warn(ot_warn), .overtemp_shutdown(ot_sd),
        .post_rail_input_pins(pres), .device_active(act), .seq_start(seq),
        .hs_gate(hs_gate), .ls_gate(ls_gate), .rail_enable(rail_enable),
        .post_rail_voltage_code(code), .vout_target_mv(vout),
        .thermal_shutdown_event(tsd_ev), .irq(irq));
    apb_host i_apb_host (.clk_sys(clk_sys), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_apb_host.xfer(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        i_apb_host.xfer(1'b0, a, 32'h0, q, e);
    endtask : rd
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(OFS_IRQ_ENABLE);
        `CHK(q[NEV-1:0], IRQ_EN_RESET)
        rd(OFS_CTRL);
        `CHK(q[CTRL_EN], CTRL_EN_RESET)
        rd(8'h40);
        `CHK(e, 1'b1)
        seq <= 1'b1;
        wr(OFS_IRQ_ENABLE, 32'h7);
        // running covers soft-start too: wait for the ramp to reach the code
        repeat (60) begin
            rd(OFS_STATUS);
            if (q[STB_RUNNING] === 1'b1 && code === VCODE_RESET) break;
        end
        `CHK(q[STB_PRESENT], 1'b1)
        `CHK(rail_enable, 1'b1)
        `CHK(code, VCODE_RESET)
        // one step up, a bad pair, a write while inactive, one step down
        wr(OFS_VCODE, 32'h8);
        wr(OFS_VCODE_CHECK, 32'h7);
        repeat (12) @(posedge clk_sys);
        `CHK(vout, 11'(VOUT_MIN_MV + VOUT_STEP_MV * 8))
        wr(OFS_VCODE, 32'h7);
        wr(OFS_VCODE_CHECK, 32'h0);
        rd(OFS_VCODE);
        `CHK(q[3:0], 4'h8)
        act <= 1'b0;
        repeat (4) @(posedge clk_sys);
        wr(OFS_VCODE, 32'h7);
        wr(OFS_VCODE_CHECK, 32'h8);
        rd(OFS_VCODE);
        `CHK(q[3:0], 4'h8)
        act <= 1'b1;
        repeat (4) @(posedge clk_sys);
        wr(OFS_VCODE, 32'h7);
        wr(OFS_VCODE_CHECK, 32'h8);
        rd(OFS_VCODE_CHECK);
        `CHK(q[3:0], 4'h8)
        `CHK(code, 4'h7)
        peak <= 1'b1;
        repeat (30) @(posedge clk_sys);
        peak <= 1'b0;
        repeat (5) @(posedge clk_sys);
        ls_oc <= 1'b1;
        // a high side started before the pin was seen may run one period
        repeat (15) @(posedge clk_sys);
        repeat (30) begin
            @(posedge clk_sys);
            if (hs_gate === 1'b1) hs_seen = 1'b1;
        end
        `CHK(hs_seen, 1'b0)
        `CHK(ls_gate, 1'b1)
        rd(OFS_IRQ_STATUS);
        `CHK(q[EV_OC], 1'b0)
        repeat (20) @(posedge clk_sys);
        rd(OFS_IRQ_STATUS);
        `CHK(q[EV_OC], 1'b1)
        `CHK(irq, 1'b1)
        `CHK(rail_enable, 1'b1)
        ls_oc <= 1'b0;
        wr(OFS_IRQ_CLEAR, 32'h1);
        ot_warn <= 1'b1;
        repeat (6) @(posedge clk_sys);
        `CHK(irq, 1'b1)
        rd(OFS_STATUS);
        `CHK(q[STB_OTW_LIVE], 1'b1)
        ot_warn <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd(OFS_STATUS);
        `CHK(q[STB_OTW_LIVE], 1'b0)
        rd(OFS_IRQ_STATUS);
        `CHK(q[2:0], 3'h2)
        wr(OFS_IRQ_CLEAR, 32'h2);
        rd(OFS_IRQ_STATUS);
        `CHK(q[2:0], 3'h0)
        `CHK(irq, 1'b0)
        ot_sd <= 1'b1;
        repeat (8) @(posedge clk_sys);
        `CHK(rail_enable, 1'b0)
        rd(OFS_STATUS);
        `CHK(q[STB_TSD_ACTIVE], 1'b1)
        pres <= 1'b0;
        repeat (4) @(posedge clk_sys);
        ot_sd <= 1'b0;
        repeat (20) @(posedge clk_sys);
        `CHK(rail_enable, 1'b0)
        rd(OFS_STATUS);
        `CHK(q[STB_PRESENT], 1'b0)
        `CHK(q[STB_DETECTED], 1'b1)
        rd(OFS_IRQ_STATUS);
        `CHK(q[EV_TSD], 1'b1)
        wr(OFS_IRQ_ENABLE, 32'h0);
        repeat (3) @(posedge clk_sys);
        `CHK(irq, 1'b0)
        tally_and_finish();
    end
endmodule : post_buck_supervisor_tb
`default_nettype wire
